// *** inc/ces_regs.svh ***
`ifndef CES_REGS_SVH
`define CES_REGS_SVH

// Register byte offsets on the Wishbone bus.
`define CES_ADR_CTRL      8'h00
`define CES_ADR_OSC_DIV   8'h04
`define CES_ADR_SHUTTER   8'h08
`define CES_ADR_APERTURE  8'h0C
`define CES_ADR_INTENSITY 8'h10
`define CES_ADR_STATUS    8'h14
`define CES_ADR_IRQ_STAT  8'h18
`define CES_ADR_IRQ_MASK  8'h1C
`define CES_ADR_BRIGHT    8'h20

// Control register fields.
`define CES_CTRL_DISP_BIT   0
`define CES_CTRL_UNLOCK_BIT 1
`define CES_CTRL_RST        1'h1

// Reset values.
`define CES_OSC_DIV_RST     8'h04
`define CES_VALUE_RST       8'h00
`define CES_MASK_RST        4'h0

// Interrupt bit positions.
`define CES_IRQ_CONV  0
`define CES_IRQ_DUMP  1
`define CES_IRQ_LOCK  2
`define CES_IRQ_FAULT 3
`define CES_IRQ_W     4

// Brightness codes that mean the meter is out of range.
`define CES_BRIGHT_MIN 8'h00
`define CES_BRIGHT_MAX 8'hFF

// Timing, in the units named.
`define CES_CLK_MHZ          100
`define CES_ADC_PERIOD_MS    20
`define CES_DISP_PERIOD_MS   500
`define CES_DISP_SHOW_US     40
`define CES_CONV_NEEDED      2'h3
`define CES_DIV_STAGE7       6

`endif

// *** inc/ces_pkg.sv ***
package ces_pkg;

    typedef enum logic [1:0] {
        CES_WORD_INTENSITY,
        CES_WORD_SHUTTER,
        CES_WORD_APERTURE
    } ces_word_t;

    typedef struct packed {
        logic      valid;
        logic      dump;
        ces_word_t kind;
        logic [7:0] data;
    } ces_out_bus_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] brightness_value;
    } ces_in_bus_t;

    typedef enum {
        CES_PWR_HOLD,
        CES_PWR_CHECK,
        CES_PWR_READY,
        CES_PWR_FAULT,
        CES_PWR_LOCKED,
        CES_PWR_OFF
    } ces_pwr_t;

    typedef enum {
        CES_DSP_IDLE,
        CES_DSP_SHOW,
        CES_DSP_TV,
        CES_DSP_AV,
        CES_DSP_WAIT
    } ces_dsp_t;

endpackage

// *** hw/ces_adc_sched.sv ***
`timescale 1ns/100ps
`include "ces_regs.svh"

module ces_adc_sched
    import ces_pkg::*;
(
    // Clock and control
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        run_i,
    input  wire logic [31:0] period_i,
    // Comparator result
    input  wire logic [7:0]  value_i,
    // Results
    output ces_in_bus_t      in_bus_o,
    output logic             conv_end_o,
    output logic             three_done_o
);

    logic [31:0] cnt_reg, cnt_next;
    logic [1:0]  done_reg, done_next;
    ces_in_bus_t bus_reg, bus_next;
    logic        end_reg, end_next;

    always_comb
    begin
        cnt_next  = cnt_reg;
        done_next = done_reg;
        bus_next  = bus_reg;
        bus_next.valid = 1'b0;
        end_next  = 1'b0;
        if (!run_i)
        begin
            // Losing supply acts as a power-up clear, so the wait restarts.
            cnt_next  = '0;
            done_next = '0;
        end
        else if (cnt_reg >= period_i - 32'h1)
        begin
            cnt_next = '0;
            bus_next.valid            = 1'b1;
            bus_next.brightness_value = value_i;
            end_next = 1'b1;
            if (done_reg != `CES_CONV_NEEDED)
            begin
                done_next = done_reg + 2'h1;
            end
        end
        else
        begin
            cnt_next = cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_reg  <= '0;
            done_reg <= '0;
            bus_reg  <= '0;
            end_reg  <= 1'b0;
        end
        else if (ce_i)
        begin
            cnt_reg  <= cnt_next;
            done_reg <= done_next;
            bus_reg  <= bus_next;
            end_reg  <= end_next;
        end
    end

    assign in_bus_o     = bus_reg;
    assign conv_end_o   = end_reg;
    assign three_done_o = (done_reg == `CES_CONV_NEEDED);

endmodule // ces_adc_sched

// *** hw/ces_display.sv ***
`timescale 1ns/100ps
`include "ces_regs.svh"

module ces_display
    import ces_pkg::*;
(
    // Clock and control
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        run_i,
    input  wire logic [31:0] show_len_i,
    input  wire logic [31:0] repeat_len_i,
    // Values to show
    input  wire logic [7:0]  shutter_i,
    input  wire logic [7:0]  aperture_i,
    input  wire logic [7:0]  intensity_i,
    // Output bus
    output ces_out_bus_t     out_bus_o,
    output logic             dump_o
);

    ces_dsp_t     st_reg, st_next;
    logic [31:0]  per_reg, per_next;
    logic [31:0]  len_reg, len_next;
    ces_out_bus_t bus_reg, bus_next;

    always_comb
    begin
        st_next  = st_reg;
        len_next = len_reg;
        bus_next = bus_reg;
        bus_next.valid = 1'b0;
        bus_next.dump  = 1'b0;
        per_next = (per_reg >= repeat_len_i - 32'h1) ? '0 : per_reg + 32'h1;
        if (!run_i)
        begin
            st_next  = CES_DSP_IDLE;
            per_next = '0;
        end
        else
        begin
            unique case (st_reg)
                CES_DSP_IDLE, CES_DSP_WAIT:
                begin
                    if (st_reg == CES_DSP_IDLE || per_reg == '0)
                    begin
                        st_next  = CES_DSP_SHOW;
                        len_next = '0;
                        bus_next.valid = 1'b1;
                        bus_next.kind  = CES_WORD_INTENSITY;
                        bus_next.data  = intensity_i;
                    end
                end
                CES_DSP_SHOW:
                begin
                    len_next = len_reg + 32'h1;
                    if (len_reg >= show_len_i - 32'h1)
                    begin
                        st_next        = CES_DSP_TV;
                        bus_next.valid = 1'b1;
                        bus_next.dump  = 1'b1;
                        bus_next.kind  = CES_WORD_SHUTTER;
                        bus_next.data  = shutter_i;
                    end
                end
                CES_DSP_TV:
                begin
                    st_next        = CES_DSP_AV;
                    bus_next.valid = 1'b1;
                    bus_next.dump  = 1'b1;
                    bus_next.kind  = CES_WORD_APERTURE;
                    bus_next.data  = aperture_i;
                end
                CES_DSP_AV:
                begin
                    st_next = CES_DSP_WAIT;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_reg  <= CES_DSP_IDLE;
            per_reg <= '0;
            len_reg <= '0;
            bus_reg <= '0;
        end
        else if (ce_i)
        begin
            st_reg  <= st_next;
            per_reg <= per_next;
            len_reg <= len_next;
            bus_reg <= bus_next;
        end
    end

    assign out_bus_o = bus_reg;
    assign dump_o    = bus_reg.valid & bus_reg.dump & (bus_reg.kind == CES_WORD_SHUTTER);

endmodule // ces_display

// *** hw/ces_top.sv ***
// The Wishbone register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "ces_regs.svh"

module ces_top
    import ces_pkg::*;
#(
    parameter int ADC_PERIOD_CYC  = `CES_ADC_PERIOD_MS * 1000 * `CES_CLK_MHZ,
    parameter int DISP_PERIOD_CYC = `CES_DISP_PERIOD_MS * 1000 * `CES_CLK_MHZ
)
(
    // Clock, reset, enable
    input  wire logic        CLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        CE_I,
    // Wishbone slave
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic [31:0]      DAT_O,
    output logic             ACK_O,
    // Camera pins
    input  wire logic        HALF_PRESS_SWITCH_I,
    input  wire logic        RELEASE_SWITCH_I,
    input  wire logic        REGULATED_SUPPLY_REF_I,
    input  wire logic        LOW_BATTERY_FLAG_I,
    input  wire logic [7:0]  BRIGHTNESS_VALUE_I,
    // Oscillator and timing
    output logic             CLOCK_PULSE_O,
    output logic             BIAS_O,
    output logic             DIVIDER_STAGE_SEVEN_O,
    output logic [7:0]       TIMING_BITS_O,
    // Buses to processor side and decoder driver
    output ces_in_bus_t      IN_BUS_O,
    output ces_out_bus_t     OUT_BUS_O,
    output logic             DUMP_O,
    // Power control
    output logic             SUPPLY_LOCK_SIGNAL_O,
    output logic             POWER_SWITCH_CONTROL_O,
    output logic             CONVERSION_END_FLAG_O,
    output logic             INT_O
);

    localparam int SHOW_CYC = `CES_DISP_SHOW_US * `CES_CLK_MHZ;

    // Pin synchronisers: first stage feeds only the second.
    logic [11:0] sync1_reg, sync1_next;
    logic [11:0] sync2_reg, sync2_next;

    always_comb
    begin
        sync1_next = {HALF_PRESS_SWITCH_I, RELEASE_SWITCH_I, REGULATED_SUPPLY_REF_I,
                      LOW_BATTERY_FLAG_I, BRIGHTNESS_VALUE_I};
        sync2_next = sync1_reg;
    end

    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else if (CE_I)
        begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    logic       half_s;
    logic       release_s;
    logic       ref_s;
    logic       lowbat_s;
    logic [7:0] bright_s;

    assign half_s    = sync2_reg[11];
    assign release_s = sync2_reg[10];
    assign ref_s     = sync2_reg[9];
    assign lowbat_s  = sync2_reg[8];
    assign bright_s  = sync2_reg[7:0];

    // Software registers.
    logic       disp_en_reg, disp_en_next;
    logic [7:0] osc_div_reg, osc_div_next;
    logic [7:0] tv_reg, tv_next;
    logic [7:0] av_reg, av_next;
    logic [7:0] inten_reg, inten_next;
    logic [`CES_IRQ_W-1:0] mask_reg, mask_next;
    logic [`CES_IRQ_W-1:0] stat_reg, stat_next;
    logic [31:0] dat_reg, dat_next;
    logic        ack_reg, ack_next;
    logic        unlock_req;
    logic [`CES_IRQ_W-1:0] events;
    ces_pwr_t    pwr_reg, pwr_next;
    ces_in_bus_t in_bus;
    logic        conv_end;
    logic        three_done;

    // Oscillator, divider and phases.
    logic [7:0] osc_cnt_reg, osc_cnt_next;
    logic       pulse_reg, pulse_next;
    logic [6:0] div_reg, div_next;
    logic [7:0] tb_reg, tb_next;
    logic       bias_reg, bias_next;

    function automatic logic [7:0] onehot8(input logic [2:0] idx);
        onehot8 = 8'h01 << idx;
    endfunction

    always_comb
    begin
        osc_cnt_next = osc_cnt_reg;
        pulse_next   = 1'b0;
        div_next     = div_reg;
        tb_next      = tb_reg;
        if (!ref_s)
        begin
            osc_cnt_next = '0;
            div_next     = '0;
            tb_next      = '0;
        end
        else if (osc_cnt_reg >= osc_div_reg)
        begin
            osc_cnt_next = '0;
            pulse_next   = 1'b1;
            div_next     = div_reg + 7'h1;
            tb_next = onehot8({div_reg[`CES_DIV_STAGE7], div_reg[1:0]});
        end
        else
        begin
            osc_cnt_next = osc_cnt_reg + 8'h1;
        end
        // reference and clock
        // Bias latches on the first pulse, so a divider wrap can never drop it.
        bias_next = ref_s & (bias_reg | pulse_reg);
    end

    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            osc_cnt_reg <= '0;
            pulse_reg   <= 1'b0;
            div_reg     <= '0;
            tb_reg      <= '0;
            bias_reg    <= 1'b0;
        end
        else if (CE_I)
        begin
            osc_cnt_reg <= osc_cnt_next;
            pulse_reg   <= pulse_next;
            div_reg     <= div_next;
            tb_reg      <= tb_next;
            bias_reg    <= bias_next;
        end
    end

    // Supply is on while the half press holds it or the lock holds the transistor.
    logic supply_on;
    logic fault;
    logic lock_low;

    assign lock_low  = (pwr_reg == CES_PWR_LOCKED);
    assign supply_on = half_s | lock_low;
    assign fault     = lowbat_s | (bright_s == `CES_BRIGHT_MIN) |
                       (bright_s == `CES_BRIGHT_MAX);

    ces_adc_sched u_adc (
        .clk_i        (CLK_I),
        .rst_i        (SYS_RST_I),
        .ce_i         (CE_I),
        .run_i        (supply_on & ref_s),
        .period_i     (32'(ADC_PERIOD_CYC)),
        .value_i      (bright_s),
        .in_bus_o     (in_bus),
        .conv_end_o   (conv_end),
        .three_done_o (three_done)
    );

    logic dump;

    ces_display u_disp (
        .clk_i        (CLK_I),
        .rst_i        (SYS_RST_I),
        .ce_i         (CE_I),
        .run_i        (supply_on & disp_en_reg & (pwr_reg != CES_PWR_HOLD)),
        .show_len_i   (32'(SHOW_CYC)),
        .repeat_len_i (32'(DISP_PERIOD_CYC)),
        .shutter_i    (tv_reg),
        .aperture_i   (av_reg),
        .intensity_i  (inten_reg),
        .out_bus_o    (OUT_BUS_O),
        .dump_o       (dump)
    );

    // Power sequence. A fault blocks the lock, so a weak battery never starts exposure.
    always_comb
    begin
        pwr_next = pwr_reg;
        unique case (pwr_reg)
            CES_PWR_HOLD:
            begin
                if (three_done)
                begin
                    pwr_next = CES_PWR_CHECK;
                end
            end
            CES_PWR_CHECK, CES_PWR_FAULT, CES_PWR_READY:
            begin
                if (fault)
                begin
                    pwr_next = CES_PWR_FAULT;
                end
                else if (release_s && pwr_reg == CES_PWR_READY)
                begin
                    pwr_next = CES_PWR_LOCKED;
                end
                else
                begin
                    pwr_next = CES_PWR_READY;
                end
            end
            CES_PWR_LOCKED:
            begin
                if (unlock_req)
                begin
                    pwr_next = CES_PWR_OFF;
                end
            end
            CES_PWR_OFF:
            begin
                if (!half_s)
                begin
                    pwr_next = CES_PWR_HOLD;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            pwr_reg <= CES_PWR_HOLD;
        end
        else if (CE_I)
        begin
            pwr_reg <= pwr_next;
        end
    end

    // Wishbone slave: one wait state, unmapped reads return zero.
    // A write lands at the edge where the master samples ack, never earlier.
    logic wr;

    assign wr         = CYC_I & STB_I & WE_I & ack_reg & SEL_I[0];
    assign unlock_req = wr & (ADR_I == `CES_ADR_CTRL) & DAT_I[`CES_CTRL_UNLOCK_BIT];
    assign events     = {(pwr_next == CES_PWR_FAULT) & (pwr_reg != CES_PWR_FAULT),
                         (pwr_next == CES_PWR_LOCKED) & (pwr_reg != CES_PWR_LOCKED),
                         dump, conv_end};

    always_comb
    begin
        disp_en_next = disp_en_reg;
        osc_div_next = osc_div_reg;
        tv_next      = tv_reg;
        av_next      = av_reg;
        inten_next   = inten_reg;
        mask_next    = mask_reg;
        stat_next    = stat_reg;
        ack_next     = CYC_I & STB_I & ~ack_reg;
        dat_next     = '0;
        if (wr)
        begin
            unique case (ADR_I)
                `CES_ADR_CTRL:      disp_en_next = DAT_I[`CES_CTRL_DISP_BIT];
                `CES_ADR_OSC_DIV:   osc_div_next = DAT_I[7:0];
                `CES_ADR_SHUTTER:   tv_next      = DAT_I[7:0];
                `CES_ADR_APERTURE:  av_next      = DAT_I[7:0];
                `CES_ADR_INTENSITY: inten_next   = DAT_I[7:0];
                `CES_ADR_IRQ_STAT:  stat_next    = stat_reg & ~DAT_I[`CES_IRQ_W-1:0];
                `CES_ADR_IRQ_MASK:  mask_next    = DAT_I[`CES_IRQ_W-1:0];
                default:            dat_next     = '0;
            endcase
        end
        // New events win over a clear in the same cycle.
        stat_next = stat_next | events;
        if (CYC_I && STB_I && !WE_I && !ack_reg)
        begin
            unique case (ADR_I)
                `CES_ADR_CTRL:      dat_next = {31'h0, disp_en_reg};
                `CES_ADR_OSC_DIV:   dat_next = {24'h0, osc_div_reg};
                `CES_ADR_SHUTTER:   dat_next = {24'h0, tv_reg};
                `CES_ADR_APERTURE:  dat_next = {24'h0, av_reg};
                `CES_ADR_INTENSITY: dat_next = {24'h0, inten_reg};
                `CES_ADR_STATUS:    dat_next = {24'h0, fault, three_done, supply_on,
                                                 lock_low, 1'b0, 3'(pwr_reg)};
                `CES_ADR_IRQ_STAT:  dat_next = {28'h0, stat_reg};
                `CES_ADR_IRQ_MASK:  dat_next = {28'h0, mask_reg};
                `CES_ADR_BRIGHT:    dat_next = {24'h0, in_bus.brightness_value};
                default:            dat_next = '0;
            endcase
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            disp_en_reg <= `CES_CTRL_RST;
            osc_div_reg <= `CES_OSC_DIV_RST;
            tv_reg      <= `CES_VALUE_RST;
            av_reg      <= `CES_VALUE_RST;
            inten_reg   <= `CES_VALUE_RST;
            mask_reg    <= `CES_MASK_RST;
            stat_reg    <= '0;
            ack_reg     <= 1'b0;
            dat_reg     <= '0;
        end
        else if (CE_I)
        begin
            disp_en_reg <= disp_en_next;
            osc_div_reg <= osc_div_next;
            tv_reg      <= tv_next;
            av_reg      <= av_next;
            inten_reg   <= inten_next;
            mask_reg    <= mask_next;
            stat_reg    <= stat_next;
            ack_reg     <= ack_next;
            dat_reg     <= dat_next;
        end
    end

    assign DAT_O                 = dat_reg;
    assign ACK_O                 = ack_reg;
    assign CLOCK_PULSE_O         = pulse_reg;
    assign BIAS_O                = bias_reg;
    assign DIVIDER_STAGE_SEVEN_O = div_reg[`CES_DIV_STAGE7];
    assign TIMING_BITS_O         = tb_reg;
    assign IN_BUS_O              = in_bus;
    assign DUMP_O                = dump;
    assign CONVERSION_END_FLAG_O = conv_end;
    assign INT_O                 = |(stat_reg & mask_reg);
    assign SUPPLY_LOCK_SIGNAL_O   = ~lock_low;
    assign POWER_SWITCH_CONTROL_O = ~lock_low;

endmodule // ces_top

// *** verif/ces_top_chk.sv ***
`timescale 1ns/100ps
module ces_top_chk
    import ces_pkg::*;
#(
    parameter int ADC_PERIOD_CYC  = 50,
    parameter int DISP_PERIOD_CYC = 20000
)
(
    // Clock, reset and bus
    input wire logic        CLK_I,
    input wire logic        SYS_RST_I,
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic        ACK_O,
    input wire logic [31:0] DAT_O,
    // Camera side
    input wire logic        RELEASE_SWITCH_I,
    input wire logic        CLOCK_PULSE_O,
    input wire logic        BIAS_O,
    input wire logic [7:0]  TIMING_BITS_O,
    input ces_in_bus_t      IN_BUS_O,
    input ces_out_bus_t     OUT_BUS_O,
    input wire logic        DUMP_O,
    input wire logic        SUPPLY_LOCK_SIGNAL_O,
    input wire logic        POWER_SWITCH_CONTROL_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    sequence s_tv;
        OUT_BUS_O.valid && OUT_BUS_O.dump && OUT_BUS_O.kind == CES_WORD_SHUTTER;
    endsequence
    sequence s_av;
        OUT_BUS_O.valid && OUT_BUS_O.kind == CES_WORD_APERTURE;
    endsequence
    property p_osc; $rose(BIAS_O) |-> ##[1:300] CLOCK_PULSE_O; endproperty
    property p_phase; $onehot0(TIMING_BITS_O); endproperty
    property p_conv; IN_BUS_O.valid |=> !IN_BUS_O.valid [*8]; endproperty
    property p_dump; DUMP_O |-> s_tv ##1 s_av; endproperty
    property p_idle;
        OUT_BUS_O.valid && !OUT_BUS_O.dump && !$past(DUMP_O)
            |-> OUT_BUS_O.kind == CES_WORD_INTENSITY;
    endproperty
    property p_pwr; POWER_SWITCH_CONTROL_O == SUPPLY_LOCK_SIGNAL_O; endproperty
    property p_lock; $fell(SUPPLY_LOCK_SIGNAL_O) |-> $past(RELEASE_SWITCH_I, 2); endproperty
    property p_ack; CYC_I && STB_I && !ACK_O |=> ACK_O; endproperty
    property p_ack1; ACK_O |=> !ACK_O && DAT_O == 32'h0; endproperty
    a_osc: assert property (p_osc) else $error("no clock pulse");
    a_phase: assert property (p_phase) else $error("phase bits not one-hot");
    a_conv: assert property (p_conv) else $error("conversions too close");
    a_dump: assert property (p_dump) else $error("bad dump words");
    a_idle: assert property (p_idle) else $error("bad idle word");
    a_pwr: assert property (p_pwr) else $error("switch differs from lock");
    a_lock: assert property (p_lock) else $error("lock without release");
    a_ack: assert property (p_ack) else $error("no ack");
    a_ack1: assert property (p_ack1) else $error("ack or data held");
endmodule // ces_top_chk

bind ces_top ces_top_chk #(.ADC_PERIOD_CYC(ADC_PERIOD_CYC), .DISP_PERIOD_CYC(DISP_PERIOD_CYC))
u_chk (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O),
    .DAT_O(DAT_O), .RELEASE_SWITCH_I(RELEASE_SWITCH_I), .CLOCK_PULSE_O(CLOCK_PULSE_O),
    .BIAS_O(BIAS_O), .TIMING_BITS_O(TIMING_BITS_O), .IN_BUS_O(IN_BUS_O), .OUT_BUS_O(OUT_BUS_O),
    .DUMP_O(DUMP_O), .SUPPLY_LOCK_SIGNAL_O(SUPPLY_LOCK_SIGNAL_O),
    .POWER_SWITCH_CONTROL_O(POWER_SWITCH_CONTROL_O));

// *** verif/ces_dd_model.sv ***
`timescale 1ns/100ps
module ces_dd_model
    import ces_pkg::*;
(
    // Clock and bus
    input wire logic    clk_i,
    input ces_out_bus_t bus_i,
    // Shown values
    output logic [7:0]  tv_o,
    output logic [7:0]  av_o,
    output logic [7:0]  int_o
);
    logic armed = 1'b0;
    // decode dump words.
    // An aperture word counts only after a dumped shutter word, as a real driver would.
    always @(posedge clk_i)
    begin
        if (bus_i.valid && bus_i.dump && bus_i.kind == CES_WORD_SHUTTER)
        begin
            tv_o <= bus_i.data;
            armed <= 1'b1;
        end
        else if (bus_i.valid && armed && bus_i.kind == CES_WORD_APERTURE)
        begin
            av_o <= bus_i.data;
            armed <= 1'b0;
        end
        if (bus_i.valid && bus_i.kind == CES_WORD_INTENSITY)
            int_o <= bus_i.data;
    end
endmodule // ces_dd_model

// *** verif/ces_top_tb.sv ***
`timescale 1ns/100ps
`include "ces_regs.svh"
module ces_top_tb
    import ces_pkg::*;
;
    logic         clk, rst, cyc, stb, we, half, rel, vref, lowb, ce;
    logic         ack, cpo, bias, d7, lock, pwr, conv, irq, dump;
    logic [7:0]   adr, bv, tbits, tv, av, inten;
    logic [31:0]  wdat, dat_o;
    ces_in_bus_t  ib;
    ces_out_bus_t ob;
    int           n_fail = 0;
    int           checks = 0;
    int           c;

    always #5 clk = ~clk;

    ces_top #(.ADC_PERIOD_CYC(50), .DISP_PERIOD_CYC(20000)) DUT (
        .CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(4'hF), .DAT_I(wdat), .DAT_O(dat_o), .ACK_O(ack),
        .HALF_PRESS_SWITCH_I(half), .RELEASE_SWITCH_I(rel), .REGULATED_SUPPLY_REF_I(vref),
        .LOW_BATTERY_FLAG_I(lowb), .BRIGHTNESS_VALUE_I(bv), .CLOCK_PULSE_O(cpo), .BIAS_O(bias),
        .DIVIDER_STAGE_SEVEN_O(d7), .TIMING_BITS_O(tbits), .IN_BUS_O(ib), .OUT_BUS_O(ob),
        .DUMP_O(dump), .SUPPLY_LOCK_SIGNAL_O(lock), .POWER_SWITCH_CONTROL_O(pwr),
        .CONVERSION_END_FLAG_O(conv), .INT_O(irq));

    ces_dd_model u_dd (.clk_i(clk), .bus_i(ob), .tv_o(tv), .av_o(av), .int_o(inten));

    task end_of_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("ERROR %s exp %h got %h", nm, e, s);
        end
    endtask

    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk) n++; while (ack !== 1'b1 && n < 20);
        if (n >= 20) n_fail++;
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk($sformatf("reg %h", a), e, q & m);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    function logic sel(input int k);
        case (k)
            0: return dump;
            1: return ib.valid;
            default: return !lock;
        endcase
    endfunction

    // Waits on the chosen event; running out of time counts as a mismatch.
    task wfor(input int k, input int lim, output int n);
        n = 0;
        do @(posedge clk) n++; while (sel(k) !== 1'b1 && n < lim);
        if (n >= lim) n_fail++;
    endtask

    initial
    begin
        #1000000;
        n_fail++;
        end_of_test;
    end

    initial
    begin
        clk = 0; rst = 1; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0;
        half = 0; rel = 0; vref = 0; lowb = 0; bv = 8'h80; ce = 1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`CES_ADR_CTRL, 32'h3, 32'h1);
        rd(`CES_ADR_OSC_DIV, 32'hFF, 32'h4);
        rd(`CES_ADR_IRQ_MASK, 32'hF, 32'h0);
        rd(8'h40, 32'hFFFFFFFF, 32'h0);
        chk("bias", 32'h0, bias);
        chk("stage7", 32'h0, d7);
        chk("phases off", 32'h0, tbits);
        wr(`CES_ADR_SHUTTER, 32'h5A);
        wr(`CES_ADR_APERTURE, 32'h3C);
        wr(`CES_ADR_INTENSITY, 32'h77);
        rd(`CES_ADR_SHUTTER, 32'hFFFFFFFF, 32'h5A);
        vref <= 1'b1;
        half <= 1'b1;
        rel <= 1'b1;
        repeat (20) @(posedge clk);
        rel <= 1'b0;
        chk("lock", 32'h1, lock);
        c = 0;
        repeat (100) begin @(posedge clk); if (cpo === 1'b1) c++; end
        chk("pulses", 32'd20, c);
        chk("bias", 32'h1, bias);
        chk("phases", 32'h1, $countones(tbits));
        repeat (200) @(posedge clk);
        rd(`CES_ADR_STATUS, 32'hC7, 32'h42);
        wfor(1, 100, c);
        chk("conv end", 32'h1, conv);
        chk("in bus", 32'h80, ib.brightness_value);
        // A low clock enable must freeze the phase bits, which otherwise move every pulse.
        ce <= 1'b0;
        @(posedge clk);
        c = tbits;
        repeat (20) @(posedge clk);
        ce <= 1'b1;
        chk("frozen phases", c, tbits);
        rd(`CES_ADR_BRIGHT, 32'hFF, 32'h80);
        wr(`CES_ADR_IRQ_MASK, 32'h1);
        chk("irq on", 32'h1, irq);
        wr(`CES_ADR_IRQ_MASK, 32'h0);
        chk("irq off", 32'h0, irq);
        wr(`CES_ADR_IRQ_STAT, 32'hF);
        rd(`CES_ADR_IRQ_STAT, 32'hE, 32'h0);
        wfor(0, 30000, c);
        repeat (2) @(posedge clk);
        chk("tv", 32'h5A, tv);
        chk("av", 32'h3C, av);
        chk("intensity", 32'h77, inten);
        rel <= 1'b1;
        wfor(2, 50, c);
        chk("switch", 32'h0, pwr);
        rd(`CES_ADR_IRQ_STAT, 32'h6, 32'h6);
        wfor(0, 30000, c);
        wfor(0, 30000, c);
        chk("period", 32'd20000, c);
        wr(`CES_ADR_CTRL, 32'h3);
        repeat (3) @(posedge clk);
        chk("unlock", 32'h1, lock);
        chk("switch off", 32'h1, pwr);
        rd(`CES_ADR_STATUS, 32'h7, 32'h5);
        end_of_test;
    end
endmodule // ces_top_tb
